/* logic/spdpm_mux.sv */
// pad multiplexer for decoder 0 index/home and spi 0, with a small spi bit engine
`timescale 1ns/1ps
// Notes on behaviour
// - index pad defaults to decoder index
// - home pad defaults to decoder home
// - four port e pads default to spi
// - clearing port c bit drops pull-up
// - clearing port e bit drops pull-up
// - gpio pads individually input or output
// - clock pad drives in master, input slave
// - master-out driven by master, slave listens
// - master-out data settles half cycle early
// - master-in driven by slave, master listens
// - unselected slave floats master-in
// - master-in data settles half cycle early
// - slave select marks transfer for us
module spdpm_mux
   import spdpm_pkg::*;
(
   input logic CORE_CLK,
   input logic RST,
   // pads
   input logic [PAD_COUNT-1:0] PAD_I,
   output logic [PAD_COUNT-1:0] PAD_O,
   output logic [PAD_COUNT-1:0] PAD_OE,
   output logic [PAD_COUNT-1:0] PAD_PU,
   // configuration
   input logic FSEL_WE,
   input logic [2*PAD_COUNT-1:0] FSEL_DATA,
   output logic [2*PAD_COUNT-1:0] FSEL_STATE,
   input logic PORT_C_PULLUP_ENABLE_WE,
   input logic [PORTC_PUR_WIDTH-1:0] PORT_C_PULLUP_ENABLE_DATA,
   output logic [PORTC_PUR_WIDTH-1:0] PORT_C_PULLUP_ENABLE,
   input logic PORT_E_PULLUP_ENABLE_WE,
   input logic [PORTE_PUR_WIDTH-1:0] PORT_E_PULLUP_ENABLE_DATA,
   output logic [PORTE_PUR_WIDTH-1:0] PORT_E_PULLUP_ENABLE,
   input logic GPIO_DIR_WE,
   input logic [PAD_COUNT-1:0] GPIO_DIR_DATA,
   input logic GPIO_OUT_WE,
   input logic [PAD_COUNT-1:0] GPIO_OUT_DATA,
   output logic [PAD_COUNT-1:0] GPIO_IN,
   // decoder 0 and timer a
   output logic DECODER0_INDEX_INPUT,
   output logic DECODER0_HOME_INPUT,
   input logic TIMER_A_CHANNEL_TWO_OUT,
   input logic TIMER_A_CHANNEL_TWO_OE,
   output logic TIMER_A_CHANNEL_TWO_IN,
   input logic TIMER_A_CHANNEL_THREE_OUT,
   input logic TIMER_A_CHANNEL_THREE_OE,
   output logic TIMER_A_CHANNEL_THREE_IN,
   // spi 0 user side
   input logic SPI_MASTER,
   input logic SPI_START,
   input logic [SPI_BITS-1:0] SPI_TX_DATA,
   output logic [SPI_BITS-1:0] SPI_RX_DATA,
   output logic SPI_DONE,
   output logic SPI_BUSY
);

   ////////////////////////////////////////////////////////////////////////////
   // configuration state
   spdpm_func_t fsel [PAD_COUNT];
   spdpm_func_t next_fsel [PAD_COUNT];
   logic [PORTC_PUR_WIDTH-1:0] portc_pur;
   logic [PORTC_PUR_WIDTH-1:0] next_portc_pur;
   logic [PORTE_PUR_WIDTH-1:0] porte_pur;
   logic [PORTE_PUR_WIDTH-1:0] next_porte_pur;
   logic [PAD_COUNT-1:0] gpio_dir;
   logic [PAD_COUNT-1:0] next_gpio_dir;
   logic [PAD_COUNT-1:0] gpio_out;
   logic [PAD_COUNT-1:0] next_gpio_out;

   always_comb begin
      next_portc_pur = portc_pur;
      next_porte_pur = porte_pur;
      next_gpio_dir = gpio_dir;
      next_gpio_out = gpio_out;
      for (int i = 0; i < PAD_COUNT; i++) begin
         next_fsel[i] = fsel[i];
         // unknown code, or a timer on a pad without one, leaves the pad alone
         if (FSEL_WE && FSEL_DATA[2*i +: 2] != 2'h3 &&
             (PAD_HAS_TIMER[i] || spdpm_func_t'(FSEL_DATA[2*i +: 2]) != FUNC_TIMER)) begin
            next_fsel[i] = spdpm_func_t'(FSEL_DATA[2*i +: 2]);
         end
      end
      if (PORT_C_PULLUP_ENABLE_WE) begin
         next_portc_pur = PORT_C_PULLUP_ENABLE_DATA;
      end
      if (PORT_E_PULLUP_ENABLE_WE) begin
         next_porte_pur = PORT_E_PULLUP_ENABLE_DATA;
      end
      if (GPIO_DIR_WE) begin
         next_gpio_dir = GPIO_DIR_DATA;
      end
      if (GPIO_OUT_WE) begin
         next_gpio_out = GPIO_OUT_DATA;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         for (int i = 0; i < PAD_COUNT; i++) begin
            fsel[i] <= FUNC_PERIPH;
         end
         portc_pur <= PORTC_PUR_RESET;
         porte_pur <= PORTE_PUR_RESET;
         gpio_dir <= GPIO_DIR_RESET;
         gpio_out <= GPIO_OUT_RESET;
      end else begin
         fsel <= next_fsel;
         portc_pur <= next_portc_pur;
         porte_pur <= next_porte_pur;
         gpio_dir <= next_gpio_dir;
         gpio_out <= next_gpio_out;
      end
   end

   assign PAD_PU = {porte_pur, portc_pur};
   assign PORT_C_PULLUP_ENABLE = portc_pur;
   assign PORT_E_PULLUP_ENABLE = porte_pur;

   ////////////////////////////////////////////////////////////////////////////
   // pad cells
   spdpm_drv_t periph_drv [PAD_COUNT];
   spdpm_drv_t timer_drv [PAD_COUNT];
   spdpm_drv_t pad_drv [PAD_COUNT];
   logic [PAD_COUNT-1:0] periph_in;
   logic [PAD_COUNT-1:0] timer_in;
   logic [PAD_COUNT-1:0] gpio_in_raw;
   logic slave_sel;
   logic [SPI_BITS-1:0] tx_shift;
   logic sclk_out;

   // select is active low; a deselected pad reads idle high
   assign slave_sel = !SPI_MASTER && !periph_in[PAD_SS];

   always_comb begin
      for (int i = 0; i < PAD_COUNT; i++) begin
         periph_drv[i] = '0;
         timer_drv[i] = '0;
      end
      timer_drv[PAD_INDEX] = '{o: TIMER_A_CHANNEL_TWO_OUT, oe: TIMER_A_CHANNEL_TWO_OE};
      timer_drv[PAD_HOME] = '{o: TIMER_A_CHANNEL_THREE_OUT, oe: TIMER_A_CHANNEL_THREE_OE};
      periph_drv[PAD_SCLK] = '{o: sclk_out, oe: SPI_MASTER};
      periph_drv[PAD_MOSI] = '{o: tx_shift[SPI_BITS-1], oe: SPI_MASTER};
      periph_drv[PAD_MISO] = '{o: tx_shift[SPI_BITS-1], oe: slave_sel};
   end

   for (genvar g = 0; g < PAD_COUNT; g++) begin : g_pad
      spdpm_pad_cell u_cell (
         .FSEL(fsel[g]),
         .PERIPH_DRV(periph_drv[g]),
         .TIMER_DRV(timer_drv[g]),
         .GPIO_DRV('{o: gpio_out[g], oe: gpio_dir[g]}),
         .PAD_IN(PAD_I[g]),
         .IDLE_LEVEL(PAD_IDLE_LEVEL[g]),
         .PAD_DRV(pad_drv[g]),
         .PERIPH_IN(periph_in[g]),
         .TIMER_IN(timer_in[g]),
         .GPIO_IN(gpio_in_raw[g])
      );
      assign PAD_O[g] = pad_drv[g].o;
      assign PAD_OE[g] = pad_drv[g].oe;
      assign FSEL_STATE[2*g +: 2] = fsel[g];
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered copies of pad inputs toward decoder, timer and gpio
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         DECODER0_INDEX_INPUT <= 1'b0;
         DECODER0_HOME_INPUT <= 1'b0;
         TIMER_A_CHANNEL_TWO_IN <= 1'b0;
         TIMER_A_CHANNEL_THREE_IN <= 1'b0;
         GPIO_IN <= '0;
      end else begin
         DECODER0_INDEX_INPUT <= periph_in[PAD_INDEX];
         DECODER0_HOME_INPUT <= periph_in[PAD_HOME];
         TIMER_A_CHANNEL_TWO_IN <= timer_in[PAD_INDEX];
         TIMER_A_CHANNEL_THREE_IN <= timer_in[PAD_HOME];
         GPIO_IN <= gpio_in_raw;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // spi bit engine: data moves on the falling edge, is sampled on the rising
   spdpm_spi_state_t spi_state;
   spdpm_spi_state_t next_spi_state;
   logic [HALF_CNT_W-1:0] half_cnt;
   logic [HALF_CNT_W-1:0] next_half_cnt;
   logic [BIT_CNT_W-1:0] bit_cnt;
   logic [BIT_CNT_W-1:0] next_bit_cnt;
   logic next_sclk_out;
   logic [SPI_BITS-1:0] next_tx_shift;
   logic [SPI_BITS-1:0] rx_shift;
   logic [SPI_BITS-1:0] next_rx_shift;
   logic [SPI_BITS-1:0] next_rx_data;
   logic next_done;
   logic sclk_in_q;
   logic sclk_rise;
   logic sclk_fall;

   assign sclk_rise = periph_in[PAD_SCLK] && !sclk_in_q;
   assign sclk_fall = !periph_in[PAD_SCLK] && sclk_in_q;

   always_comb begin
      next_spi_state = spi_state;
      next_half_cnt = half_cnt;
      next_bit_cnt = bit_cnt;
      next_sclk_out = sclk_out;
      next_tx_shift = tx_shift;
      next_rx_shift = rx_shift;
      next_rx_data = SPI_RX_DATA;
      next_done = 1'b0;
      case (spi_state)
         SPI_IDLE: begin
            next_sclk_out = 1'b0;
            if (SPI_MASTER) begin
               if (SPI_START) begin
                  // first bit out now, first rising edge a half period later
                  next_tx_shift = SPI_TX_DATA;
                  next_half_cnt = '0;
                  next_bit_cnt = '0;
                  next_spi_state = SPI_RUN;
               end
            end else if (!slave_sel) begin
               // deselected slave keeps its first bit ready ahead of the clock
               next_tx_shift = SPI_TX_DATA;
               next_bit_cnt = '0;
            end else if (sclk_rise) begin
               next_rx_shift = {rx_shift[SPI_BITS-2:0], periph_in[PAD_MOSI]};
               next_bit_cnt = bit_cnt + 1'b1;
               if (bit_cnt == BIT_LAST) begin
                  next_rx_data = {rx_shift[SPI_BITS-2:0], periph_in[PAD_MOSI]};
                  next_done = 1'b1;
                  next_bit_cnt = '0;
                  next_tx_shift = SPI_TX_DATA;
               end
            end else if (sclk_fall && bit_cnt != '0) begin
               next_tx_shift = {tx_shift[SPI_BITS-2:0], 1'b0};
            end
         end
         SPI_RUN: begin
            next_half_cnt = half_cnt + 1'b1;
            if (half_cnt == HALF_LAST) begin
               next_half_cnt = '0;
               if (!sclk_out) begin
                  next_sclk_out = 1'b1;
                  next_rx_shift = {rx_shift[SPI_BITS-2:0], periph_in[PAD_MISO]};
                  next_bit_cnt = bit_cnt + 1'b1;
               end else begin
                  next_sclk_out = 1'b0;
                  if (bit_cnt == BIT_ALL) begin
                     // cleared so a later slave byte starts counting from zero
                     next_bit_cnt = '0;
                     next_rx_data = rx_shift;
                     next_done = 1'b1;
                     next_spi_state = SPI_IDLE;
                  end else begin
                     next_tx_shift = {tx_shift[SPI_BITS-2:0], 1'b0};
                  end
               end
            end
         end
         default: begin
            next_spi_state = SPI_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         spi_state <= SPI_IDLE;
         half_cnt <= '0;
         bit_cnt <= '0;
         sclk_out <= 1'b0;
         tx_shift <= '0;
         rx_shift <= '0;
         SPI_RX_DATA <= '0;
         SPI_DONE <= 1'b0;
         // pad idles high on its pull-up; avoids a false rise after reset
         sclk_in_q <= 1'b1;
      end else begin
         spi_state <= next_spi_state;
         half_cnt <= next_half_cnt;
         bit_cnt <= next_bit_cnt;
         sclk_out <= next_sclk_out;
         tx_shift <= next_tx_shift;
         rx_shift <= next_rx_shift;
         SPI_RX_DATA <= next_rx_data;
         SPI_DONE <= next_done;
         sclk_in_q <= periph_in[PAD_SCLK];
      end
   end

   // a mode change mid transfer is not guarded; software must wait for idle
   assign SPI_BUSY = (spi_state == SPI_RUN) || slave_sel;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence s_master_half;
      spi_state == SPI_RUN && half_cnt == HALF_LAST;
   endsequence

   property p_index_default;
      $fell(RST) |-> fsel[PAD_INDEX] == FUNC_PERIPH;
   endproperty
   a_index_default: assert property (p_index_default) else $error("index pad not decoder");

   property p_home_default;
      $fell(RST) |-> fsel[PAD_HOME] == FUNC_PERIPH && PAD_OE[PAD_HOME] == 1'b0;
   endproperty
   a_home_default: assert property (p_home_default) else $error("home pad not decoder");

   property p_spi_default;
      $fell(RST) |-> FSEL_STATE[2*PAD_SS+1:2*PAD_SCLK] == 8'h00;
   endproperty
   a_spi_default: assert property (p_spi_default) else $error("spi pads not spi");

   property p_portc_pullup;
      PORT_C_PULLUP_ENABLE_WE |=> PAD_PU[PAD_HOME:PAD_INDEX] == $past(PORT_C_PULLUP_ENABLE_DATA);
   endproperty
   a_portc_pullup: assert property (p_portc_pullup) else $error("port c pull-up wrong");

   property p_porte_pullup;
      PORT_E_PULLUP_ENABLE_WE |=> PAD_PU[PAD_SS:PAD_SCLK] == $past(PORT_E_PULLUP_ENABLE_DATA);
   endproperty
   a_porte_pullup: assert property (p_porte_pullup) else $error("port e pull-up wrong");

   logic gpio_all_gpio;
   always_comb begin
      gpio_all_gpio = 1'b1;
      for (int i = 0; i < PAD_COUNT; i++) begin
         gpio_all_gpio = gpio_all_gpio && fsel[i] == FUNC_GPIO && !FSEL_WE;
      end
   end
   property p_gpio_drive;
      GPIO_DIR_WE && gpio_all_gpio |=> PAD_OE == $past(GPIO_DIR_DATA);
   endproperty
   a_gpio_drive: assert property (p_gpio_drive) else $error("gpio direction ignored");

   property p_sclk_dir;
      fsel[PAD_SCLK] == FUNC_PERIPH |-> PAD_OE[PAD_SCLK] == SPI_MASTER;
   endproperty
   a_sclk_dir: assert property (p_sclk_dir) else $error("clock pad direction wrong");

   property p_data_dir;
      fsel[PAD_MOSI] == FUNC_PERIPH && fsel[PAD_MISO] == FUNC_PERIPH |->
         PAD_OE[PAD_MOSI] == SPI_MASTER && !(SPI_MASTER && PAD_OE[PAD_MISO]);
   endproperty
   a_data_dir: assert property (p_data_dir) else $error("data pad direction wrong");

   property p_mosi_half;
      s_master_half ##0 !sclk_out |=>
         sclk_out && $stable(tx_shift) ##1 (sclk_out && $stable(tx_shift)) [*2];
   endproperty
   a_mosi_half: assert property (p_mosi_half) else $error("data moved at sample edge");

   property p_miso_float;
      fsel[PAD_MISO] == FUNC_PERIPH && periph_in[PAD_SS] |-> !PAD_OE[PAD_MISO];
   endproperty
   a_miso_float: assert property (p_miso_float) else $error("miso driven unselected");

   property p_slave_hold;
      !SPI_MASTER && spi_state == SPI_IDLE && slave_sel && sclk_fall && bit_cnt != '0
         |=> tx_shift == {$past(tx_shift[SPI_BITS-2:0]), 1'b0};
   endproperty
   a_slave_hold: assert property (p_slave_hold) else $error("slave shift late");

   property p_select_gate;
      !SPI_MASTER && spi_state == SPI_IDLE && !slave_sel |=> bit_cnt == '0 && !SPI_DONE;
   endproperty
   a_select_gate: assert property (p_select_gate) else $error("unselected slave received");

   property p_one_function;
      !PAD_HAS_TIMER[PAD_SCLK] |-> FSEL_STATE[2*PAD_SS+1:2*PAD_SCLK] != 8'h55 &&
         fsel[PAD_SCLK] != FUNC_TIMER && fsel[PAD_SS] != FUNC_TIMER;
   endproperty
   a_one_function: assert property (p_one_function) else $error("pad has bad function");

endmodule // spdpm_mux

/* logic/spdpm_pad_cell.sv */
// one pad: picks exactly one function for the driver and routes the input
`timescale 1ns/1ps
module spdpm_pad_cell
   import spdpm_pkg::*;
(
   input spdpm_func_t FSEL,
   input spdpm_drv_t PERIPH_DRV,
   input spdpm_drv_t TIMER_DRV,
   input spdpm_drv_t GPIO_DRV,
   input logic PAD_IN,
   input logic IDLE_LEVEL,
   output spdpm_drv_t PAD_DRV,
   output logic PERIPH_IN,
   output logic TIMER_IN,
   output logic GPIO_IN
);

   ////////////////////////////////////////////////////////////////////////////
   // unselected functions see their idle level, never the pad
   always_comb begin
      PAD_DRV = '0;
      PERIPH_IN = IDLE_LEVEL;
      TIMER_IN = IDLE_LEVEL;
      GPIO_IN = IDLE_LEVEL;
      case (FSEL)
         FUNC_PERIPH: begin
            PAD_DRV = PERIPH_DRV;
            PERIPH_IN = PAD_IN;
         end
         FUNC_TIMER: begin
            PAD_DRV = TIMER_DRV;
            TIMER_IN = PAD_IN;
         end
         FUNC_GPIO: begin
            PAD_DRV = GPIO_DRV;
            GPIO_IN = PAD_IN;
         end
         default: begin
            PAD_DRV = '0;
         end
      endcase
   end

endmodule // spdpm_pad_cell

/* logic/spdpm_pkg.sv */
// shared constants and types for the decoder / spi pad multiplexer
package spdpm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // pad numbering inside the block
   localparam int PAD_COUNT = 6;
   localparam int PAD_INDEX = 0;
   localparam int PAD_HOME = 1;
   localparam int PAD_SCLK = 2;
   localparam int PAD_MOSI = 3;
   localparam int PAD_MISO = 4;
   localparam int PAD_SS = 5;

   // bit positions of the pads in the port pull-up enable registers
   localparam int PORTC_PUR_LSB = 6;
   localparam int PORTC_PUR_WIDTH = 2;
   localparam int PORTE_PUR_LSB = 4;
   localparam int PORTE_PUR_WIDTH = 4;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [1:0] PORTC_PUR_RESET = 2'h3;
   localparam logic [3:0] PORTE_PUR_RESET = 4'hf;
   localparam logic [5:0] GPIO_DIR_RESET = 6'h00;
   localparam logic [5:0] GPIO_OUT_RESET = 6'h00;
   // level a function sees while its pad belongs to another function
   localparam logic [5:0] PAD_IDLE_LEVEL = 6'h20;
   // only the two port c pads offer a timer channel
   localparam logic [5:0] PAD_HAS_TIMER = 6'h03;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int SPI_HALF_NS = 500;
   localparam int SPI_HALF_CYCLES = (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HALF_CNT_W = 5;
   localparam logic [HALF_CNT_W-1:0] HALF_LAST = HALF_CNT_W'(SPI_HALF_CYCLES - 1);
   localparam int SPI_BITS = 8;
   localparam int BIT_CNT_W = 4;
   localparam logic [BIT_CNT_W-1:0] BIT_LAST = BIT_CNT_W'(SPI_BITS - 1);
   localparam logic [BIT_CNT_W-1:0] BIT_ALL = BIT_CNT_W'(SPI_BITS);

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {FUNC_PERIPH, FUNC_TIMER, FUNC_GPIO} spdpm_func_t;
   typedef enum logic {SPI_IDLE, SPI_RUN} spdpm_spi_state_t;
   typedef struct packed {
      logic o;
      logic oe;
   } spdpm_drv_t;

endpackage

/* sim/spdpm_peer.sv */
// spi peer and quadrature encoder model seen through the six pads
`timescale 1ns/1ps
module spdpm_peer
   import spdpm_pkg::*;
#(
   parameter int HALF = 25
)
(
   input logic clk,
   input logic pm,
   input logic start,
   input logic keep,
   input logic [7:0] tx,
   input logic [1:0] enc,
   input logic [5:0] dut_o,
   input logic [5:0] dut_oe,
   input logic [5:0] pu,
   output logic [5:0] pad,
   output logic [7:0] rx,
   output logic done
);
   logic [5:0] rel = 6'h15;
   logic [7:0] sh = 8'h00;
   logic [7:0] rsh = 8'h00;
   logic busy = 1'b0;
   logic sclk = 1'b0;
   logic sclk_d = 1'b0;
   logic ss = 1'b1;
   logic [5:0] po;
   logic [5:0] poe;
   int nb = 0;
   int hc = 0;
   ////////////////////////////////////////////////////////////////////////////
   // encoder always drives pads 0/1; clock and select stand still between frames
   assign po = {ss, sh[7], sh[7], sclk, enc};
   assign poe = pm ? {1'b1, 1'b0, busy, 1'b1, 2'h3}
                   : {1'b0, busy, 1'b0, 1'b0, 2'h3};
   // released lines show the pull-up, else a toggling pattern, never the last value
   assign pad = (dut_oe & dut_o) | (~dut_oe & poe & po) | (~dut_oe & ~poe & (pu | rel));
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      rel <= ~rel;
      done <= 1'b0;
      sclk_d <= pad[PAD_SCLK];
      if (start && !busy) begin
         busy <= 1'b1;
         sh <= tx;
         nb <= 0;
         hc <= 0;
         ss <= keep;
      end else if (busy && pm) begin
         // acting master: data moves on the fall, half a period ahead of the rise
         hc <= (hc == HALF - 1) ? 0 : hc + 1;
         if (hc == HALF - 1) begin
            sclk <= ~sclk;
            if (!sclk) begin
               rsh <= {rsh[6:0], pad[PAD_MISO]};
               nb <= nb + 1;
            end else if (nb == SPI_BITS) begin
               busy <= 1'b0;
               ss <= 1'b1;
               rx <= rsh;
               done <= 1'b1;
            end else begin
               sh <= sh << 1;
            end
         end
      end else if (busy) begin
         // acting slave: rise seen one cycle late, so early data shows up here
         if (pad[PAD_SCLK] && !sclk_d) begin
            rsh <= {rsh[6:0], pad[PAD_MOSI]};
            nb <= nb + 1;
         end
         if (!pad[PAD_SCLK] && sclk_d) begin
            sh <= sh << 1;
            busy <= (nb != SPI_BITS);
            done <= (nb == SPI_BITS);
            rx <= rsh;
         end
      end
   end
endmodule // spdpm_peer

/* sim/spi_decoder_pad_mux_test.sv */
// self-checking bench for the decoder / spi pad multiplexer with its peer model
`timescale 1ns/1ps
module spi_decoder_pad_mux_test;
   import spdpm_pkg::*;
   logic clk;
   logic rst;
   logic [5:0] pi, po, poe, ppu, dd, od, gi;
   logic [11:0] fd, fs;
   logic [1:0] cd, cpu, enc;
   logic [3:0] ed, epu;
   logic fw, cw, ew, dw, ow, idx, hom, t2o, t2e, t2i, t3o, t3e, t3i;
   logic sm, st, sdn, sb, pm, pst, pk, pdn;
   logic [7:0] stx, srx, ptx, prx;
   integer seed = 45;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int i;
   logic [7:0] q_rx[$];
   logic [7:0] q_pr[$];
   ////////////////////////////////////////////////////////////////////////////
   spdpm_mux spdpm_mux_i (
      .CORE_CLK(clk), .RST(rst), .PAD_I(pi), .PAD_O(po), .PAD_OE(poe), .PAD_PU(ppu),
      .FSEL_WE(fw), .FSEL_DATA(fd), .FSEL_STATE(fs),
      .PORT_C_PULLUP_ENABLE_WE(cw), .PORT_C_PULLUP_ENABLE_DATA(cd),
      .PORT_C_PULLUP_ENABLE(cpu), .PORT_E_PULLUP_ENABLE_WE(ew),
      .PORT_E_PULLUP_ENABLE_DATA(ed), .PORT_E_PULLUP_ENABLE(epu),
      .GPIO_DIR_WE(dw), .GPIO_DIR_DATA(dd), .GPIO_OUT_WE(ow), .GPIO_OUT_DATA(od),
      .GPIO_IN(gi), .DECODER0_INDEX_INPUT(idx), .DECODER0_HOME_INPUT(hom),
      .TIMER_A_CHANNEL_TWO_OUT(t2o), .TIMER_A_CHANNEL_TWO_OE(t2e),
      .TIMER_A_CHANNEL_TWO_IN(t2i), .TIMER_A_CHANNEL_THREE_OUT(t3o),
      .TIMER_A_CHANNEL_THREE_OE(t3e), .TIMER_A_CHANNEL_THREE_IN(t3i),
      .SPI_MASTER(sm), .SPI_START(st), .SPI_TX_DATA(stx), .SPI_RX_DATA(srx),
      .SPI_DONE(sdn), .SPI_BUSY(sb)
   );
   spdpm_peer spdpm_peer_i (
      .clk(clk), .pm(pm), .start(pst), .keep(pk), .tx(ptx), .enc(enc), .dut_o(po),
      .dut_oe(poe), .pu(ppu), .pad(pi), .rx(prx), .done(pdn)
   );
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [11:0] seen, input logic [11:0] want);
      n_compared++;
      if (seen !== want) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic end_sim;
      $display("compared %0d, wrong %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [4:0] m);
      @(negedge clk);
      {ow, dw, ew, cw, fw} = m;
      @(negedge clk);
      {ow, dw, ew, cw, fw} = 5'h00;
   endtask
   // one byte each way; keep holds select high so the design must ignore the clocks
   task automatic xfer(input logic mst, input logic keep);
      logic [7:0] a;
      logic [7:0] b;
      a = $random(seed);
      b = $random(seed);
      stx = a;
      ptx = b;
      pk = keep;
      if (!keep)
         q_rx.push_back(b);
      q_pr.push_back(keep ? 8'hff : a);
      st = mst;
      pst = 1'b1;
      @(negedge clk);
      st = 1'b0;
      pst = 1'b0;
      repeat (3) @(negedge clk);
      check(poe[PAD_SCLK], mst);
      check(poe[PAD_MOSI], mst);
      check(poe[PAD_MISO], !mst && !keep);
      check(sb, !keep);
      // a start while busy must not add a second byte
      st = mst;
      @(negedge clk);
      st = 1'b0;
      for (i = 0; i < 1200 && (q_rx.size() + q_pr.size()) > 0; i++)
         @(negedge clk);
      repeat (4) @(negedge clk);
      check(q_rx.size() + q_pr.size(), 0);
      check(sb, 1'b0);
      $display("transfer done, master %0d keep %0d", mst, keep);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(negedge clk) begin
      if (sdn === 1'b1) begin
         if (q_rx.size() == 0)
            check(1'b1, 1'b0);
         else
            check(srx, q_rx.pop_front());
      end
      if (pdn === 1'b1) begin
         if (q_pr.size() == 0)
            check(1'b1, 1'b0);
         else
            check(prx, q_pr.pop_front());
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         $display("wrong value at %0t: timeout", $time);
         end_sim();
      end
   end
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, fw, cw, ew, dw, ow, t2o, t2e, t3o, t3e, sm, st, pm, pst, pk} = 15'h4000;
      {fd, dd, od, stx, ptx} = '0;
      cd = 2'h3;
      ed = 4'hf;
      enc = 2'h1;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      for (i = 0; i < 2; i++) begin
         enc = i[0] ? 2'h1 : 2'h2;
         repeat (2) @(negedge clk);
         check(fs, 12'h000);
         check({hom, idx}, enc);
         check({t3i, t2i, gi}, {2'h0, PAD_IDLE_LEVEL});
         check({ppu, epu, cpu}, {6'h3f, PORTE_PUR_RESET, PORTC_PUR_RESET});
         check(poe, 6'h00);
      end
      $display("reset defaults done");
      for (i = 0; i < 4; i++) begin
         cd = $random(seed);
         ed = $random(seed);
         wr(5'h06);
         check({ppu, epu, cpu}, {ed, cd, ed, cd});
      end
      cd = 2'h3;
      ed = 4'hf;
      wr(5'h06);
      $display("pull-ups done");
      for (i = 0; i < 3; i++) begin
         fd = 12'haaa;
         dd = $random(seed);
         od = $random(seed);
         wr(5'h01);
         wr(5'h18);
         repeat (2) @(negedge clk);
         check(fs, 12'haaa);
         check(poe, dd);
         check(po & dd, od & dd);
         check(gi, (dd & od) | (~dd & {4'hf, enc}));
         check({hom, idx}, 2'h0);
      end
      // timer on pads 0/1; timer code on the clock pad is refused and keeps gpio
      fd = 12'h015;
      t2e = 1'b1;
      t2o = $random(seed);
      enc = 2'h2;
      wr(5'h01);
      repeat (2) @(negedge clk);
      check(fs, 12'h025);
      check(poe[1:0], 2'h1);
      check(po[0], t2o);
      check(t3i, 1'b1);
      check(hom, 1'b0);
      // code 3 on every pad is refused; nothing moves
      fd = 12'hfff;
      wr(5'h01);
      check(fs, 12'h025);
      fd = 12'h000;
      wr(5'h01);
      $display("gpio and timer done");
      sm = 1'b1;
      xfer(1'b1, 1'b0);
      xfer(1'b1, 1'b0);
      sm = 1'b0;
      pm = 1'b1;
      repeat (4) @(negedge clk);
      xfer(1'b0, 1'b1);
      xfer(1'b0, 1'b0);
      end_sim();
   end
endmodule // spi_decoder_pad_mux_test
